// ---- common/ssb_pkg.sv ----
// constants shared by the start-up strap and bring-up logic
// assumes one 10 MHz core clock; all offsets are serial-port addresses
package ssb_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int POR_PULSE_NS  = 75;
  // least time: round up
  localparam int POR_PULSE_CYC =
    (POR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIZ_MAX_NS    = 45;
  // longest time: round down, never below one cycle
  localparam int HIZ_MAX_CYC   = (HIZ_MAX_NS / CLK_PERIOD_NS < 1) ?
    1 : HIZ_MAX_NS / CLK_PERIOD_NS;
  localparam logic [3:0] POR_CNT_LOAD = 4'(POR_PULSE_CYC);

  // ****************************************************************
  // strap layout
  // ****************************************************************
  localparam int STRAP_W   = 8;
  localparam int PORT_LSB  = 0;
  localparam int PORT_W    = 3;
  localparam int LOAD_LSB  = 3;
  localparam int LOAD_W    = 5;
  localparam int REF_NUM   = 4;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int REG_NUM = 12;
  localparam logic [3:0] IDX_UPDATE = 4'h0;
  localparam logic [3:0] IDX_SYSCLK = 4'h1;
  localparam logic [3:0] IDX_MFPOUT = 4'h2;
  localparam logic [3:0] IDX_MFPSYN = 4'h3;
  localparam logic [3:0] IDX_IRQMOD = 4'h4;
  localparam logic [3:0] IDX_IRQMSK = 4'h5;
  localparam logic [3:0] IDX_WDOG   = 4'h6;
  localparam logic [3:0] IDX_OUTEN  = 4'h7;
  localparam logic [3:0] IDX_DISTCF = 4'h8;
  localparam logic [3:0] IDX_REFCF  = 4'h9;
  localparam logic [3:0] IDX_CALSYN = 4'ha;
  localparam logic [3:0] IDX_PROFSL = 4'hb;
  localparam logic [3:0] IDX_NONE   = 4'hf;
  localparam logic [12:0] REG_ADDR [REG_NUM] = '{
    13'h0005, 13'h0100, 13'h0200, 13'h0201, 13'h0208, 13'h0209,
    13'h0211, 13'h0400, 13'h0401, 13'h0500, 13'h0a02, 13'h0a0d};
  localparam logic [12:0] ADDR_STRAP  = 13'h0d00;
  localparam logic [12:0] ADDR_STATUS = 13'h0d01;
  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam int UPD_BIT   = 0;
  localparam int CAL_BIT   = 0;
  localparam int SYNC_BIT  = 1;
  localparam int AUTO_BIT  = 0;
  localparam int SYNEN_BIT = 3;

  // ****************************************************************
  // serial frame
  // ****************************************************************
  localparam logic [4:0] SPI_HDR_LAST = 5'h0f;
  localparam logic [4:0] SPI_DAT_LAST = 5'h17;
  localparam int SPI_RW_BIT = 15;
  typedef enum logic [1:0] {
    SPI_IDLE = 2'b00,
    SPI_HDR  = 2'b01,
    SPI_DATA = 2'b11,
    SPI_DONE = 2'b10
  } ssb_spi_state_t;
endpackage : ssb_pkg

// ---- hw/ssb_startup_bringup.sv ----
// start-up reset, strap capture, staged register file and bring-up
// assumes pins and the serial clock are asynchronous to clock; loop,
// monitors and the stored-settings loader sit outside this module
//
// Overview of operation
// - supply good makes an internal reset pulse of one 100 ns cycle (75 ns rounded up).
// - strap pins become undriven inputs one 100 ns clock cycle after that pulse starts.
// - pins stay undriven in any reset; levels latched at reset release.
// - latched bit n equals the level of strap pin n.
// - low three strap bits zero selects the SPI serial port.
// - nonzero low bits select I2C and form the low address bits.
// - upper five bits zero means no stored-settings load at release.
// - nonzero upper bits start the load with that condition value.
// - update bit 0 applies staged system clock settings.
// - strap pins default to unassigned undriven inputs.
// - interrupt mask resets to all blocked; pin defaults open drain.
// - watchdog stays off after reset until enabled.
// - clock outputs come up disabled until enabled by software.
// - manual profiles: after update lock to best available reference.
// - automatic profiles: start selected machines, then lock best one.
// - automatic sync releases outputs once the loop locks.
// - manual sync via set-then-clear bit or pin pulse starts outputs.
`timescale 1ns/1ns
`default_nettype none
module ssb_startup_bringup
  import ssb_pkg::*;
(
  // clock and reset
  input  wire  logic               clock,
  input  wire  logic               srst,
  // supply monitor and external reset pin
  input  wire  logic               supplyValid,
  input  wire  logic               resetPinN,
  // strap pins (two-way)
  input  wire  logic [STRAP_W-1:0] strapPinsIn,
  output var   logic [STRAP_W-1:0] strapPinsOut,
  output var   logic [STRAP_W-1:0] strapPinsOeN,
  // serial port, SPI side
  input  wire  logic               spiSclk,
  input  wire  logic               spiCsN,
  input  wire  logic               spiSdi,
  output var   logic               spiSdo,
  output var   logic               spiSdoOeN,
  // serial port mode
  output var   logic               serialIsSpi,
  output var   logic [PORT_W-1:0]  i2cAddrLow,
  // stored-settings loader
  output var   logic               loadStart,
  output var   logic [LOAD_W-1:0]  loadCondition,
  output var   logic [STRAP_W-1:0] latchedStrapValue,
  // system clock
  output var   logic [7:0]         sysclkPeriod,
  output var   logic               sysclkApply,
  output var   logic               sysclkCalStart,
  // interrupt pin setup and watchdog
  output var   logic [7:0]         irqMask,
  output var   logic               irqOpenDrain,
  output var   logic               watchdogEnable,
  // digital_lock_loop interface, same clock domain
  input  wire  logic [REF_NUM-1:0] refAvailable,
  input  wire  logic               loopLocked,
  output var   logic               loopStart,
  output var   logic [1:0]         activeRef,
  output var   logic [REF_NUM-1:0] refMachineStart,
  // clock distribution
  output var   logic [1:0]         outEnable
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [3:0] regIndex(input logic [12:0] a);
    logic [3:0] r;
    r = IDX_NONE;
    for (int i = 0; i < REG_NUM; i++) begin
      if (REG_ADDR[i] == a) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : regIndex

  // lowest index is the highest priority
  function automatic logic [1:0] bestRef(input logic [REF_NUM-1:0] m);
    logic [1:0] r;
    r = 2'h0;
    for (int i = REF_NUM - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction : bestRef

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  logic               supA_q, supB_q;
  logic               rpnA_q, rpnB_q;
  logic [STRAP_W-1:0] pinA_q, pinB_q, pinP_q;
  logic [2:0]         spiA_q, spiB_q;
  logic               sclkP_q;

  // every async input passes two flops before any logic
  always_ff @(posedge clock) begin
    supA_q  <= supplyValid;
    supB_q  <= supA_q;
    rpnA_q  <= resetPinN;
    rpnB_q  <= rpnA_q;
    pinA_q  <= strapPinsIn;
    pinB_q  <= pinA_q;
    pinP_q  <= pinB_q;
    spiA_q  <= {spiSclk, spiCsN, spiSdi};
    spiB_q  <= spiA_q;
    sclkP_q <= spiB_q[2];
  end

  // ****************************************************************
  // power-up pulse and device reset
  // ****************************************************************
  logic [3:0] porCnt_q;
  logic       devRst_q, devRstP_q;

  // loaded while supply is low, so the pulse follows its rise gap-free
  always_ff @(posedge clock) begin
    if (srst) begin
      porCnt_q <= 4'h0;
    end else if (!supB_q) begin
      porCnt_q <= POR_CNT_LOAD;
    end else if (porCnt_q != 4'h0) begin
      porCnt_q <= porCnt_q - 4'h1;
    end
  end

  // one flop gathers all reset causes, held off until supply good
  always_ff @(posedge clock) begin
    devRst_q  <= srst || (porCnt_q != 4'h0) || !rpnB_q || !supB_q;
    devRstP_q <= devRst_q;
  end

  // ****************************************************************
  // strap capture
  // ****************************************************************
  logic strapRelease;
  assign strapRelease = devRstP_q && !devRst_q;

  // the capture is taken from the synchronised pins at release
  always_ff @(posedge clock) begin
    if (srst) begin
      latchedStrapValue <= '0;
      serialIsSpi       <= 1'b1;
      i2cAddrLow        <= '0;
      loadStart         <= 1'b0;
      loadCondition     <= '0;
    end else begin
      loadStart <= 1'b0;
      if (strapRelease) begin
        latchedStrapValue <= pinB_q;
        serialIsSpi <= (pinB_q[PORT_LSB +: PORT_W] == '0);
        i2cAddrLow  <= pinB_q[PORT_LSB +: PORT_W];
        loadCondition <= pinB_q[LOAD_LSB +: LOAD_W];
        loadStart <= (pinB_q[LOAD_LSB +: LOAD_W] != '0);
      end
    end
  end

  // ****************************************************************
  // serial port (SPI mode)
  // ****************************************************************
  ssb_spi_state_t spiSt_q;
  logic [4:0]     bitCnt_q;
  logic [22:0]    shift_q;
  logic [12:0]    spiAddr_q;
  logic           spiRead_q;
  logic [7:0]     rdData_q;
  logic           wrStrobe_q;
  logic [7:0]     wrData_q;
  logic           sclkRise, sclkFall;
  logic [7:0]     stage_q [REG_NUM];
  logic [7:0]     act_q   [REG_NUM];
  logic           distSynced_q;

  assign sclkRise = spiB_q[2] && !sclkP_q;
  assign sclkFall = !spiB_q[2] && sclkP_q;

  // read mux over staged registers and status words
  function automatic logic [7:0] readReg(input logic [12:0] a);
    logic [3:0] ix;
    logic [7:0] r;
    ix = regIndex(a);
    r  = 8'h00;
    if (ix != IDX_NONE) begin
      r = stage_q[ix];
    end else if (a == ADDR_STRAP) begin
      r = latchedStrapValue;
    end else if (a == ADDR_STATUS) begin
      r = {4'h0, distSynced_q, loopLocked, activeRef};
    end
    return r;
  endfunction : readReg

  // one-byte frames: 16-bit header then 8 data bits, msb first;
  // the engine sleeps in I2C mode, which lives outside
  always_ff @(posedge clock) begin
    if (devRst_q) begin
      spiSt_q    <= SPI_IDLE;
      bitCnt_q   <= 5'h00;
      shift_q    <= '0;
      spiAddr_q  <= '0;
      spiRead_q  <= 1'b0;
      rdData_q   <= 8'h00;
      wrStrobe_q <= 1'b0;
      wrData_q   <= 8'h00;
      spiSdo     <= 1'b0;
      spiSdoOeN  <= 1'b1;
    end else begin
      wrStrobe_q <= 1'b0;
      if (spiB_q[1] || !serialIsSpi) begin
        spiSt_q   <= SPI_IDLE;
        bitCnt_q  <= 5'h00;
        spiSdoOeN <= 1'b1;
      end else begin
        case (spiSt_q)
          SPI_IDLE: begin
            spiSt_q <= SPI_HDR;
          end
          SPI_HDR: begin
            if (sclkRise) begin
              shift_q  <= {shift_q[21:0], spiB_q[0]};
              bitCnt_q <= bitCnt_q + 5'h01;
              if (bitCnt_q == SPI_HDR_LAST) begin
                spiAddr_q <= {shift_q[11:0], spiB_q[0]};
                spiRead_q <= shift_q[SPI_RW_BIT - 1];
                rdData_q  <= readReg({shift_q[11:0], spiB_q[0]});
                spiSt_q   <= SPI_DATA;
              end
            end
          end
          SPI_DATA: begin
            if (sclkFall && spiRead_q) begin
              spiSdo    <= rdData_q[7];
              rdData_q  <= {rdData_q[6:0], 1'b0};
              spiSdoOeN <= 1'b0;
            end
            if (sclkRise) begin
              shift_q  <= {shift_q[21:0], spiB_q[0]};
              bitCnt_q <= bitCnt_q + 5'h01;
              if (bitCnt_q == SPI_DAT_LAST) begin
                wrStrobe_q <= !spiRead_q;
                wrData_q   <= {shift_q[6:0], spiB_q[0]};
                spiSt_q    <= SPI_DONE;
              end
            end
          end
          SPI_DONE: begin
            spiSdoOeN <= 1'b1; // waits for chip select to rise
          end
          default: begin
            spiSt_q <= SPI_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // staged and active registers
  // ****************************************************************
  logic       ioUpdate;
  logic [3:0] wrIdx;
  assign ioUpdate = stage_q[IDX_UPDATE][UPD_BIT];
  assign wrIdx    = regIndex(spiAddr_q);

  // writes land in staging only; a write in the clearing cycle wins
  always_ff @(posedge clock) begin
    if (devRst_q) begin
      for (int i = 0; i < REG_NUM; i++) begin
        stage_q[i] <= REG_RESET;
      end
    end else begin
      if (ioUpdate) begin
        stage_q[IDX_UPDATE] <= REG_RESET;
      end
      if (wrStrobe_q && wrIdx != IDX_NONE) begin
        stage_q[wrIdx] <= wrData_q;
      end
    end
  end

  // update copies every staged value at once
  always_ff @(posedge clock) begin
    if (devRst_q) begin
      for (int i = 0; i < REG_NUM; i++) begin
        act_q[i] <= REG_RESET;
      end
    end else if (ioUpdate) begin
      for (int i = 0; i < REG_NUM; i++) begin
        act_q[i] <= stage_q[i];
      end
    end
  end

  // ****************************************************************
  // system clock, interrupt setup, watchdog
  // ****************************************************************
  logic calP_q, syncP_q;

  always_ff @(posedge clock) begin
    if (devRst_q) begin
      sysclkPeriod   <= 8'h00;
      sysclkApply    <= 1'b0;
      sysclkCalStart <= 1'b0;
      calP_q         <= 1'b0;
      irqMask        <= 8'h00;
      irqOpenDrain   <= 1'b1;
      watchdogEnable <= 1'b0;
    end else begin
      sysclkPeriod   <= act_q[IDX_SYSCLK];
      sysclkApply    <= ioUpdate;
      calP_q         <= act_q[IDX_CALSYN][CAL_BIT];
      // calibration starts when the applied bit turns on
      sysclkCalStart <= act_q[IDX_CALSYN][CAL_BIT] && !calP_q;
      irqMask        <= act_q[IDX_IRQMSK];
      irqOpenDrain   <= !act_q[IDX_IRQMOD][0];
      watchdogEnable <= act_q[IDX_WDOG][0];
    end
  end

  // ****************************************************************
  // reference acquisition
  // ****************************************************************
  logic               arm_q;
  logic               autoProf;
  logic [REF_NUM-1:0] candMask;
  assign autoProf = act_q[IDX_REFCF][AUTO_BIT];
  assign candMask = autoProf ?
    (refAvailable & act_q[IDX_PROFSL][REF_NUM-1:0]) : refAvailable;

  // armed by an update; lock starts once a candidate is available
  always_ff @(posedge clock) begin
    if (devRst_q) begin
      arm_q           <= 1'b0;
      loopStart       <= 1'b0;
      activeRef       <= 2'h0;
      refMachineStart <= '0;
    end else begin
      loopStart       <= 1'b0;
      refMachineStart <= '0;
      if (ioUpdate) begin
        arm_q <= 1'b1;
      end else if (arm_q) begin
        if (autoProf) begin
          refMachineStart <= act_q[IDX_PROFSL][REF_NUM-1:0];
        end
        if (candMask != '0) begin
          arm_q     <= 1'b0;
          loopStart <= 1'b1;
          activeRef <= bestRef(candMask);
        end
      end
    end
  end

  // ****************************************************************
  // distribution sync and outputs
  // ****************************************************************
  logic       syncPinRise;
  logic [2:0] syncPin;
  assign syncPin     = act_q[IDX_MFPSYN][2:0];
  assign syncPinRise = act_q[IDX_MFPSYN][SYNEN_BIT] &&
    pinB_q[syncPin] && !pinP_q[syncPin];

  // outputs wait for a sync; a software clear cannot undo it
  always_ff @(posedge clock) begin
    if (devRst_q) begin
      syncP_q      <= 1'b0;
      distSynced_q <= 1'b0;
      outEnable    <= 2'b00;
    end else begin
      syncP_q <= act_q[IDX_CALSYN][SYNC_BIT];
      if (act_q[IDX_DISTCF][0] && loopLocked) begin
        distSynced_q <= 1'b1;
      end else if (syncP_q && !act_q[IDX_CALSYN][SYNC_BIT]) begin
        distSynced_q <= 1'b1;
      end else if (syncPinRise) begin
        distSynced_q <= 1'b1;
      end
      outEnable <= act_q[IDX_OUTEN][1:0] & {2{distSynced_q}};
    end
  end

  // ****************************************************************
  // strap pin drive
  // ****************************************************************
  // undriven in any reset; assigned pins show the lock state
  always_ff @(posedge clock) begin
    if (devRst_q) begin
      strapPinsOeN <= '1;
      strapPinsOut <= '0;
    end else begin
      strapPinsOeN <= ~act_q[IDX_MFPOUT];
      strapPinsOut <= {STRAP_W{loopLocked}};
    end
  end

endmodule : ssb_startup_bringup
`default_nettype wire

// ---- sim/ssb_host_model.sv ----
// host controller model: sends one register frame at a time on SPI
// assumes the device samples sclk with its own unrelated core clock
`timescale 1ns/1ns
`default_nettype none
module ssb_host_model (
  // serial port
  output var  logic spiSclk,
  output var  logic spiCsN,
  output var  logic spiSdi,
  input  wire logic spiSdo,
  input  wire logic spiSdoOeN
);
  logic prevBit;

  // idle: deselected, clock low
  initial begin
    spiSclk = 1'b0;
    spiCsN  = 1'b1;
    spiSdi  = 1'b0;
    prevBit = 1'b0;
  end

  // 24 bits msb first, 800 ns each; sclk idles low between frames
  task automatic frame(input logic rd, input logic [12:0] addr,
                       input logic [7:0] wdat, output logic [7:0] rdat);
    logic [23:0] bits;
    bits   = {rd, 2'b00, addr, wdat};
    rdat   = 8'h00;
    spiCsN = 1'b0;
    #837;
    for (int i = 23; i >= 0; i--) begin
      spiSdi = bits[i];
      #400 spiSclk = 1'b1;
      // a released sdo line reads as the inverse of the last bit
      prevBit = spiSdoOeN ? ~prevBit : spiSdo;
      if (i < 8) rdat[i] = prevBit;
      #400 spiSclk = 1'b0;
    end
    spiCsN = 1'b1;
    spiSdi = ~spiSdi;
    #600;
  endtask : frame
endmodule : ssb_host_model
`default_nettype wire

// ---- sim/ssb_startup_bringup_properties.sv ----
// checker for strap capture, staged registers and bring-up outputs
// assumes it is bound into ssb_startup_bringup; one clock domain only
`timescale 1ns/1ns
`default_nettype none
module ssb_startup_bringup_properties
  import ssb_pkg::*;
(
  // clock and reset
  input wire logic               clock,
  input wire logic               srst,
  // reset sources and strap pins
  input wire logic               supplyValid,
  input wire logic               resetPinN,
  input wire logic [STRAP_W-1:0] strapPinsOeN,
  // strap results
  input wire logic               serialIsSpi,
  input wire logic [PORT_W-1:0]  i2cAddrLow,
  input wire logic               loadStart,
  input wire logic [LOAD_W-1:0]  loadCondition,
  input wire logic [STRAP_W-1:0] latchedStrapValue,
  // applied settings
  input wire logic [7:0]         sysclkPeriod,
  input wire logic               sysclkApply,
  input wire logic [7:0]         irqMask,
  input wire logic               irqOpenDrain,
  input wire logic               watchdogEnable,
  input wire logic [REF_NUM-1:0] refAvailable,
  input wire logic               loopStart,
  input wire logic [1:0]         outEnable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // ****************************************************************
  // sequences
  // ****************************************************************
  // a new strap pattern has been latched
  sequence capture_s;
    $changed(latchedStrapValue);
  endsequence
  // an update copied a nonzero period into the active set
  sequence period_new_s;
    $changed(sysclkPeriod) && (sysclkPeriod != 8'h00);
  endsequence

  // ****************************************************************
  // assertions
  // ****************************************************************
  hiz_on_por_a: assert property (
    $rose(supplyValid) |-> ##[2:6] strapPinsOeN == 8'hff)
    else $error("strap pins driven after supply rise");
  hiz_on_pin_a: assert property (
    !resetPinN |-> ##[1:6] strapPinsOeN == 8'hff)
    else $error("strap pins driven during pin reset");
  port_select_a: assert property (
    capture_s |-> ##[0:1] serialIsSpi == (latchedStrapValue[2:0] == 3'h0))
    else $error("serial mode does not follow low strap bits");
  i2c_addr_a: assert property (
    capture_s |-> ##[0:1] i2cAddrLow == latchedStrapValue[2:0])
    else $error("address bits do not follow low strap bits");
  load_skip_a: assert property (
    loadStart |-> latchedStrapValue[7:3] != 5'h00)
    else $error("load started with zero upper strap bits");
  load_cond_a: assert property (
    loadStart |-> loadCondition == latchedStrapValue[7:3] ##1 !loadStart)
    else $error("load condition wrong or start pulse too long");
  stage_apply_a: assert property (
    period_new_s |-> $past(sysclkApply))
    else $error("period changed without an apply pulse");
  irq_defaults_a: assert property (
    $fell(srst) |-> irqMask == 8'h00 && irqOpenDrain && !watchdogEnable)
    else $error("interrupt or watchdog reset value wrong");
  out_defaults_a: assert property (
    $fell(srst) |-> outEnable == 2'b00 && strapPinsOeN == 8'hff)
    else $error("outputs or strap pins not off after reset");
  lock_start_a: assert property (
    loopStart |-> $past(refAvailable) != 4'h0)
    else $error("loop started with no reference available");
endmodule : ssb_startup_bringup_properties

bind ssb_startup_bringup ssb_startup_bringup_properties ssb_props_i (
  .clock(clock), .srst(srst), .supplyValid(supplyValid),
  .resetPinN(resetPinN), .strapPinsOeN(strapPinsOeN),
  .serialIsSpi(serialIsSpi), .i2cAddrLow(i2cAddrLow),
  .loadStart(loadStart), .loadCondition(loadCondition),
  .latchedStrapValue(latchedStrapValue), .sysclkPeriod(sysclkPeriod),
  .sysclkApply(sysclkApply), .irqMask(irqMask),
  .irqOpenDrain(irqOpenDrain), .watchdogEnable(watchdogEnable),
  .refAvailable(refAvailable), .loopStart(loopStart),
  .outEnable(outEnable));
`default_nettype wire

// ---- sim/test_ssb_startup_bringup.sv ----
// self-checking bench: strap capture, staged registers, bring-up
// assumes the host model in ssb_host_model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module test_ssb_startup_bringup import ssb_pkg::*;;
  logic       clock = 1'b0;
  logic       srst = 1'b1;
  logic       supplyValid = 1'b1;
  logic       resetPinN = 1'b1;
  logic       loopLocked = 1'b0;
  logic [3:0] refAvailable = 4'h0;
  logic [7:0] pull = 8'h05;
  logic [7:0] pinsIn, pinsOut, pinsOeN, irqMask, period, latched;
  logic       sclk, csN, sdi, sdo, sdoOeN, isSpi, loadStart, apply;
  logic       calStart, irqOd, wdog, loopStart;
  logic [2:0] addrLow;
  logic [4:0] cond;
  logic [1:0] activeRef, outEn;
  logic [3:0] machStart, seenMach;
  logic       seenLoad, seenApply, seenCal, seenStart;
  int         badCount = 0;
  int         checked = 0;

  // 10 MHz core clock
  always #50 clock = ~clock;

  // board pulls set undriven strap pins
  assign pinsIn = (pinsOut & ~pinsOeN) | (pull & pinsOeN);

  ssb_startup_bringup ssb_startup_bringup_i (
    .clock(clock), .srst(srst), .supplyValid(supplyValid),
    .resetPinN(resetPinN), .strapPinsIn(pinsIn),
    .strapPinsOut(pinsOut), .strapPinsOeN(pinsOeN),
    .spiSclk(sclk), .spiCsN(csN), .spiSdi(sdi), .spiSdo(sdo),
    .spiSdoOeN(sdoOeN), .serialIsSpi(isSpi), .i2cAddrLow(addrLow),
    .loadStart(loadStart), .loadCondition(cond),
    .latchedStrapValue(latched), .sysclkPeriod(period),
    .sysclkApply(apply), .sysclkCalStart(calStart), .irqMask(irqMask),
    .irqOpenDrain(irqOd), .watchdogEnable(wdog),
    .refAvailable(refAvailable), .loopLocked(loopLocked),
    .loopStart(loopStart), .activeRef(activeRef),
    .refMachineStart(machStart), .outEnable(outEn));

  ssb_host_model ssb_host_model_i (
    .spiSclk(sclk), .spiCsN(csN), .spiSdi(sdi), .spiSdo(sdo),
    .spiSdoOeN(sdoOeN));

  // one-cycle pulses land in sticky flags
  always @(posedge clock) begin
    if (loadStart) seenLoad <= 1'b1;
    if (apply) seenApply <= 1'b1;
    if (calStart) seenCal <= 1'b1;
    if (loopStart) seenStart <= 1'b1;
    seenMach <= seenMach | machStart;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic clr;
    {seenLoad, seenApply, seenCal, seenStart, seenMach} = 8'h00;
  endtask : clr

  task automatic cmp(input string what, input logic [7:0] exp, got);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] r;
    ssb_host_model_i.frame(1'b0, a, d, r);
    tick(4);
  endtask : wr

  // read and compare
  task automatic rdc(input string w, input logic [12:0] a,
                     input logic [7:0] e);
    logic [7:0] v;
    ssb_host_model_i.frame(1'b1, a, 8'h00, v);
    tick(1);
    cmp(w, e, v);
  endtask : rdc

  // staged set goes active
  task automatic upd;
    wr(13'h0005, 8'h01);
    tick(3);
  endtask : upd

  task automatic finishTest;
    $display("comparisons %0d, mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finishTest

  // ****************************************************************
  // tests
  // ****************************************************************
  // hang guard; tests take ~570 us
  initial begin
    #3000000;
    badCount++;
    finishTest;
  end

  initial begin
    clr;
    tick(2);
    srst = 1'b0;
    tick(10);
    cmp("spi mode", 8'h00, isSpi);
    cmp("i2c low address", 8'h05, addrLow);
    cmp("latched straps", 8'h05, latched);
    cmp("load start", 8'h00, seenLoad);
    cmp("irq mask", 8'h00, irqMask);
    cmp("irq open drain", 8'h01, irqOd);
    cmp("watchdog", 8'h00, wdog);
    cmp("out enable", 8'h00, outEn);
    cmp("strap oe", 8'hff, pinsOeN);
    // supply dip: fresh capture
    pull = 8'h60;
    supplyValid = 1'b0;
    tick(4);
    supplyValid = 1'b1;
    tick(12);
    cmp("por latched", 8'h60, latched);
    cmp("por condition", 8'h0c, cond);
    cmp("por spi mode", 8'h01, isSpi);
    // period staged until update
    wr(13'h0100, 8'h3c);
    cmp("period before update", 8'h00, period);
    rdc("period staged", 13'h0100, 8'h3c);
    clr;
    upd;
    cmp("period applied", 8'h3c, period);
    cmp("apply pulse", 8'h01, seenApply);
    rdc("update self clear", 13'h0005, 8'h00);
    rdc("strap readback", 13'h0d00, 8'h60);
    rdc("unmapped read", 13'h0123, 8'h00);
    // calibration set, then cleared
    clr;
    wr(13'h0a02, 8'h01);
    upd;
    cmp("cal start", 8'h01, seenCal);
    clr;
    wr(13'h0a02, 8'h00);
    upd;
    cmp("cal on clear", 8'h00, seenCal);
    // irq, watchdog, strap drive
    wr(13'h0209, 8'hff);
    wr(13'h0211, 8'h01);
    wr(13'h0208, 8'h01);
    wr(13'h0200, 8'h81);
    upd;
    cmp("irq mask set", 8'hff, irqMask);
    cmp("irq push pull", 8'h00, irqOd);
    cmp("watchdog on", 8'h01, wdog);
    cmp("strap oe driven", 8'h7e, pinsOeN);
    // pin reset: release, capture, defaults
    clr;
    pull = 8'ha8;
    resetPinN = 1'b0;
    tick(6);
    cmp("oe in pin reset", 8'hff, pinsOeN);
    resetPinN = 1'b1;
    tick(12);
    cmp("pin latched", 8'ha8, latched);
    cmp("pin load start", 8'h01, seenLoad);
    cmp("pin condition", 8'h15, cond);
    cmp("irq mask reset", 8'h00, irqMask);
    // manual: lowest index wins
    refAvailable = 4'b0110;
    clr;
    upd;
    tick(4);
    cmp("manual start", 8'h01, seenStart);
    cmp("manual ref", 8'h01, activeRef);
    // manual sync: set, then clear
    wr(13'h0400, 8'h03);
    upd;
    cmp("outputs before sync", 8'h00, outEn);
    wr(13'h0a02, 8'h02);
    upd;
    cmp("outputs sync set", 8'h00, outEn);
    wr(13'h0a02, 8'h00);
    upd;
    tick(3);
    cmp("outputs after sync", 8'h03, outEn);
    // auto profiles, lock sync, no load
    refAvailable = 4'h0;
    pull = 8'h00;
    clr;
    srst = 1'b1;
    tick(2);
    srst = 1'b0;
    tick(10);
    cmp("zero load start", 8'h00, seenLoad);
    wr(13'h0500, 8'h01);
    wr(13'h0a0d, 8'h0c);
    wr(13'h0401, 8'h01);
    wr(13'h0400, 8'h03);
    refAvailable = 4'b1010;
    upd;
    tick(4);
    cmp("auto start", 8'h01, seenStart);
    cmp("auto ref", 8'h03, activeRef);
    cmp("machines", 8'h0c, seenMach);
    cmp("outputs before lock", 8'h00, outEn);
    loopLocked = 1'b1;
    tick(4);
    cmp("outputs on lock", 8'h03, outEn);
    cmp("strap pin data", 8'hff, pinsOut);
    finishTest;
  end
endmodule : test_ssb_startup_bringup
`default_nettype wire
